/* File: edge_divider.sv */
// divides a sampled clock by counting its rising edges and toggling a level
`timescale 1ns/1ps
module edge_divider (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic src_level,
  input wire logic bypass,
  input wire logic [7:0] half,
  output logic out_r
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic out_nxt;

  // a half period shrunk below the running count wraps at once instead of running to 255
  always_comb
  begin
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    if (bypass)
    begin
      cnt_nxt = 8'h00;
      out_nxt = src_level;
    end
    else if (tick)
    begin
      if (cnt_r + 8'h01 >= half)
      begin
        cnt_nxt = 8'h00;
        out_nxt = ~out_r;
      end
      else
      begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r <= 8'h00;
      out_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end
endmodule

/* File: scan_ctl.sv */
// scan interface control slice: flag source, counter clear, state gating, dividers
// ----------------------------------------------------------------------------
// Summary of operation
// - bits 6-4 pick the flag-zero setting edge
// - clear-on-read bit 15 empties counter when read
// - bit 11 gates state bit seven into next-state
// - bit 10 gates state bit six into next-state
// - trigger divides aux clock by 2(2A+1)(2B+1)
// - bits 3-2 divide aux clock by 1,2,4,8
// - bits 1-0 divide sub-main clock by 1,2,4,8
// ----------------------------------------------------------------------------
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "scan_defs.svh"
module scan_ctl (
  input wire logic clk,
  input wire logic resetn,
  input scan_pkg::reg_req_t req,
  output logic [15:0] rdata_r,
  input wire logic [3:0] front_end_out,
  input wire logic count_event,
  input wire logic state_bit_six,
  input wire logic state_bit_seven,
  input wire logic aux_clk_in,
  input wire logic sub_main_clock,
  output logic scan_flag_zero_r,
  output logic state_bit_six_used_r,
  output logic state_bit_seven_used_r,
  output logic trigger_r,
  output logic aux_div_r,
  output logic sub_main_div_r,
  output logic [2:0] counter_enables_r
);

  // ----------------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------------
  logic [15:0] src_out_r;
  logic [15:0] src_out_nxt;
  logic [15:0] cnt_div_r;
  logic [15:0] cnt_div_nxt;
  logic [15:0] event_counter_r;
  logic [15:0] event_counter_nxt;
  logic [15:0] rdata_nxt;
  logic scan_flag_zero_nxt;
  logic [3:0] fe_r;
  logic [3:0] fe_prev_r;
  logic flag_event;
  logic [1:0] sel_bit;
  logic sel_now;
  logic sel_prev;
  logic [15:0] read_mux;

  scan_pkg::flag_src_t flag_src;
  assign flag_src = scan_pkg::flag_src_t'(src_out_r[`SCAN_SRC_HI:`SCAN_SRC_LO]);

  // ----------------------------------------------------------------------------
  // flag zero source
  // ----------------------------------------------------------------------------
  // the upper code bits name the output bit, the lowest picks set or reset edge
  assign sel_bit = flag_src[2:1];
  assign sel_now = fe_r[sel_bit];
  assign sel_prev = fe_prev_r[sel_bit];
  assign flag_event = flag_src[0] ? (sel_prev & ~sel_now) : (~sel_prev & sel_now);

  // ----------------------------------------------------------------------------
  // read mux and register updates
  // ----------------------------------------------------------------------------
  always_comb
  begin
    read_mux = 16'h0000;
    if (req.addr == `SCAN_OFF_SRC_OUT)
    begin
      read_mux = {src_out_r[15:`SCAN_FE_HI + 1], fe_r};
    end
    else if (req.addr == `SCAN_OFF_CNT_DIV)
    begin
      read_mux = cnt_div_r;
    end
    else if (req.addr == `SCAN_OFF_COUNTER)
    begin
      read_mux = event_counter_r;
    end
    else if (req.addr == `SCAN_OFF_STATUS)
    begin
      read_mux = {15'h0000, scan_flag_zero_r};
    end
  end

  always_comb
  begin
    src_out_nxt = src_out_r;
    cnt_div_nxt = cnt_div_r;
    event_counter_nxt = event_counter_r;
    scan_flag_zero_nxt = scan_flag_zero_r;
    rdata_nxt = 16'h0000;
    if (req.rd)
    begin
      rdata_nxt = read_mux;
    end
    if (req.wr && req.addr == `SCAN_OFF_SRC_OUT)
    begin
      // the front-end output bits are read-only
      src_out_nxt = {req.wdata[15:`SCAN_FE_HI + 1], 4'h0};
    end
    if (req.wr && req.addr == `SCAN_OFF_CNT_DIV)
    begin
      cnt_div_nxt = req.wdata;
    end
    if (req.rd && req.addr == `SCAN_OFF_COUNTER && cnt_div_r[`SCAN_CLR_ON_READ])
    begin
      event_counter_nxt = 16'h0000;
    end
    else if (req.wr && req.addr == `SCAN_OFF_COUNTER)
    begin
      event_counter_nxt = req.wdata;
    end
    // an event in the clearing cycle is kept: it counts from zero
    if (count_event)
    begin
      event_counter_nxt = event_counter_nxt + 16'h0001;
    end
    if (req.wr && req.addr == `SCAN_OFF_STATUS && req.wdata[`SCAN_STATUS_FLAG0])
    begin
      scan_flag_zero_nxt = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (flag_event)
    begin
      scan_flag_zero_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      src_out_r <= `SCAN_RST_SRC_OUT;
      cnt_div_r <= `SCAN_RST_CNT_DIV;
      event_counter_r <= `SCAN_RST_COUNTER;
      scan_flag_zero_r <= 1'b0;
      rdata_r <= 16'h0000;
      fe_r <= 4'h0;
      fe_prev_r <= 4'h0;
    end
    else
    begin
      src_out_r <= src_out_nxt;
      cnt_div_r <= cnt_div_nxt;
      event_counter_r <= event_counter_nxt;
      scan_flag_zero_r <= scan_flag_zero_nxt;
      rdata_r <= rdata_nxt;
      fe_r <= front_end_out;
      fe_prev_r <= fe_r;
    end
  end

  // ----------------------------------------------------------------------------
  // state bit gating and counter enables
  // ----------------------------------------------------------------------------
  logic q6_nxt;
  logic q7_nxt;

  always_comb
  begin
    q6_nxt = cnt_div_r[`SCAN_Q6_EN] & state_bit_six;
    q7_nxt = cnt_div_r[`SCAN_Q7_EN] & state_bit_seven;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_bit_six_used_r <= 1'b0;
      state_bit_seven_used_r <= 1'b0;
      counter_enables_r <= 3'h0;
    end
    else
    begin
      state_bit_six_used_r <= q6_nxt;
      state_bit_seven_used_r <= q7_nxt;
      counter_enables_r <= cnt_div_r[`SCAN_CNT_EN_HI:`SCAN_CNT_EN_LO];
    end
  end

  // ----------------------------------------------------------------------------
  // clock dividers
  // ----------------------------------------------------------------------------
  // the source clocks are sampled, so they must run below a quarter of clk
  logic aux_r;
  logic aux_prev_r;
  logic sm_r;
  logic sm_prev_r;
  logic aux_tick;
  logic sm_tick;
  logic [7:0] trig_half;
  logic [7:0] aux_half;
  logic [7:0] sm_half;
  logic [3:0] odd_a;
  logic [3:0] odd_b;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aux_r <= 1'b0;
      aux_prev_r <= 1'b0;
      sm_r <= 1'b0;
      sm_prev_r <= 1'b0;
    end
    else
    begin
      aux_r <= aux_clk_in;
      aux_prev_r <= aux_r;
      sm_r <= sub_main_clock;
      sm_prev_r <= sm_r;
    end
  end

  assign aux_tick = aux_r & ~aux_prev_r;
  assign sm_tick = sm_r & ~sm_prev_r;

  // toggling every (2A+1)(2B+1) edges gives a full period of twice that
  assign odd_a = {cnt_div_r[`SCAN_DIVA_HI:`SCAN_DIVA_LO], 1'b1};
  assign odd_b = {cnt_div_r[`SCAN_DIVB_HI:`SCAN_DIVB_LO], 1'b1};
  assign trig_half = 8'(odd_a) * 8'(odd_b);
  assign aux_half = 8'(8'h01 << (cnt_div_r[`SCAN_AUXDIV_HI:`SCAN_AUXDIV_LO] - 2'h1));
  assign sm_half = 8'(8'h01 << (cnt_div_r[`SCAN_SMDIV_HI:`SCAN_SMDIV_LO] - 2'h1));

  edge_divider u_trigger (
    .clk(clk),
    .resetn(resetn),
    .tick(aux_tick),
    .src_level(aux_r),
    .bypass(1'b0),
    .half(trig_half),
    .out_r(trigger_r)
  );

  edge_divider u_aux (
    .clk(clk),
    .resetn(resetn),
    .tick(aux_tick),
    .src_level(aux_r),
    .bypass(cnt_div_r[`SCAN_AUXDIV_HI:`SCAN_AUXDIV_LO] == 2'h0),
    .half(aux_half),
    .out_r(aux_div_r)
  );

  edge_divider u_sub_main (
    .clk(clk),
    .resetn(resetn),
    .tick(sm_tick),
    .src_level(sm_r),
    .bypass(cnt_div_r[`SCAN_SMDIV_HI:`SCAN_SMDIV_LO] == 2'h0),
    .half(sm_half),
    .out_r(sub_main_div_r)
  );

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_read_counter;
    req.rd && req.addr == `SCAN_OFF_COUNTER;
  endsequence

  a_flag_sets_edge: assert property (flag_event |=> scan_flag_zero_r)
    else $error("flag zero not set after selected edge");
  a_flag_code_map: assert property (
    (flag_src == scan_pkg::SRC_B2_RESET && $fell(fe_r[2])) |=> scan_flag_zero_r)
    else $error("reset code of bit two did not set flag zero");
  a_counter_clear_read: assert property (
    (s_read_counter ##0 (cnt_div_r[`SCAN_CLR_ON_READ] && !count_event))
    |=> event_counter_r == 16'h0000 && rdata_r == $past(event_counter_r))
    else $error("clear on read did not return then clear");
  a_counter_keep_read: assert property (
    (s_read_counter ##0 (!cnt_div_r[`SCAN_CLR_ON_READ] && !count_event && !req.wr))
    |=> $stable(event_counter_r))
    else $error("counter changed on plain read");
  a_q7_gating: assert property (
    !cnt_div_r[`SCAN_Q7_EN] |=> !state_bit_seven_used_r)
    else $error("state bit seven used while disabled");
  a_q6_gating: assert property (
    (cnt_div_r[`SCAN_Q6_EN] && state_bit_six) |=> state_bit_six_used_r)
    else $error("state bit six not used while enabled");
  a_trigger_on_tick: assert property (
    !aux_tick |=> $stable(trigger_r))
    else $error("trigger moved without an aux edge");
  a_aux_bypass: assert property (
    cnt_div_r[`SCAN_AUXDIV_HI:`SCAN_AUXDIV_LO] == 2'h0 |=> aux_div_r == $past(aux_r))
    else $error("aux divide by one does not follow source");
  a_sm_hold: assert property (
    (cnt_div_r[`SCAN_SMDIV_HI:`SCAN_SMDIV_LO] != 2'h0 && !sm_tick) |=> $stable(sub_main_div_r))
    else $error("sub-main divider moved without an edge");

endmodule

/* File: scan_defs.svh */
// offsets, field positions and reset values of the scan control slice
`ifndef SCAN_DEFS_SVH
`define SCAN_DEFS_SVH

`define SCAN_OFF_SRC_OUT 3'h0
`define SCAN_OFF_CNT_DIV 3'h1
`define SCAN_OFF_COUNTER 3'h2
`define SCAN_OFF_STATUS 3'h3

`define SCAN_RST_SRC_OUT 16'h0000
`define SCAN_RST_CNT_DIV 16'h0000
`define SCAN_RST_COUNTER 16'h0000

`define SCAN_SRC_LO 4
`define SCAN_SRC_HI 6
`define SCAN_FE_HI 3
`define SCAN_CLR_ON_READ 15
`define SCAN_CNT_EN_HI 14
`define SCAN_CNT_EN_LO 12
`define SCAN_Q7_EN 11
`define SCAN_Q6_EN 10
`define SCAN_DIVB_HI 9
`define SCAN_DIVB_LO 7
`define SCAN_DIVA_HI 6
`define SCAN_DIVA_LO 4
`define SCAN_AUXDIV_HI 3
`define SCAN_AUXDIV_LO 2
`define SCAN_SMDIV_HI 1
`define SCAN_SMDIV_LO 0
`define SCAN_STATUS_FLAG0 0

`endif

/* File: scan_pkg.sv */
// types shared by the scan control slice
package scan_pkg;

  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // each output bit owns two codes: set event, then reset event
  typedef enum logic [2:0] {
    SRC_B0_SET = 3'h0,
    SRC_B0_RESET = 3'h1,
    SRC_B1_SET = 3'h2,
    SRC_B1_RESET = 3'h3,
    SRC_B2_SET = 3'h4,
    SRC_B2_RESET = 3'h5,
    SRC_B3_SET = 3'h6,
    SRC_B3_RESET = 3'h7
  } flag_src_t;

endpackage

/* File: test_scan_ctl.sv */
// self-checking testbench for the scan control slice
`timescale 1ns/1ps
module test_scan_ctl;
  logic clk;
  logic resetn;
  scan_pkg::reg_req_t req;
  scan_pkg::reg_req_t idle;
  logic [15:0] rdata_r;
  logic [3:0] front_end_out;
  logic count_event, state_bit_six, state_bit_seven, aux_clk_in, sub_main_clock;
  logic scan_flag_zero_r, state_bit_six_used_r, state_bit_seven_used_r;
  logic trigger_r, aux_div_r, sub_main_div_r;
  logic [2:0] counter_enables_r;
  int num_errors = 0;
  int checked = 0;
  int sel = 0;
  bit counting = 0;
  logic prev = 1'b0;
  logic mon;
  logic [15:0] cnt;
  // flag rows: {source code, output bit mask, rising edge}
  logic [7:0] rows [8] = '{8'h03, 8'h22, 8'h45, 8'h64, 8'h89, 8'ha8, 8'hd1, 8'hf0};
  logic [8:0] trig [3] = '{9'h000, 9'h010, 9'h1a0};
  int trig_exp [3] = '{32, 10, 2};
  int trig_win [3] = '{64, 60, 140};

  scan_ctl i_scan_ctl (
    .clk(clk),
    .resetn(resetn),
    .req(req),
    .rdata_r(rdata_r),
    .front_end_out(front_end_out),
    .count_event(count_event),
    .state_bit_six(state_bit_six),
    .state_bit_seven(state_bit_seven),
    .aux_clk_in(aux_clk_in),
    .sub_main_clock(sub_main_clock),
    .scan_flag_zero_r(scan_flag_zero_r),
    .state_bit_six_used_r(state_bit_six_used_r),
    .state_bit_seven_used_r(state_bit_seven_used_r),
    .trigger_r(trigger_r),
    .aux_div_r(aux_div_r),
    .sub_main_div_r(sub_main_div_r),
    .counter_enables_r(counter_enables_r)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req <= idle;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] e, input string nm);
    @(posedge clk) req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req <= idle;
    #1 check(nm, rdata_r, e);
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // source periods of eight clocks keep the sampled clock well under clk/4
  task automatic run_src(input bit sub, input int n);
    repeat (n)
    begin
      @(posedge clk)
      begin
        if (sub) sub_main_clock <= 1'b1;
        else aux_clk_in <= 1'b1;
      end
      waitc(3);
      @(posedge clk)
      begin
        if (sub) sub_main_clock <= 1'b0;
        else aux_clk_in <= 1'b0;
      end
      waitc(3);
    end
  endtask

  // counting whole output periods makes the result independent of divider phase
  task automatic measure(input bit sub, input int warm, input int n);
    run_src(sub, warm);
    cnt = 16'h0000;
    counting = 1;
    run_src(sub, n);
    counting = 0;
  endtask

  always @(negedge clk)
  begin
    mon = (sel == 0) ? aux_div_r : (sel == 1) ? sub_main_div_r : trigger_r;
    if (counting && mon === 1'b1 && prev === 1'b0) cnt = cnt + 16'h0001;
    prev = mon;
  end

  initial
  begin
    #1ms;
    num_errors++;
    results();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    idle = '{addr: 3'h0, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
    req = idle;
    resetn = 1'b0;
    front_end_out = 4'h0;
    count_event = 1'b0;
    state_bit_six = 1'b1;
    state_bit_seven = 1'b1;
    aux_clk_in = 1'b0;
    sub_main_clock = 1'b0;
    waitc(16);
    @(posedge clk) resetn <= 1'b1;
    rd(3'h0, 16'h0000, "reg0 reset");
    rd(3'h1, 16'h0000, "reg1 reset");
    rd(3'h2, 16'h0000, "counter reset");
    for (int i = 0; i < 8; i++)
    begin
      logic [3:0] pre, post;
      post = rows[i][0] ? rows[i][4:1] : 4'h0;
      pre = rows[i][0] ? 4'h0 : rows[i][4:1];
      wr(3'h0, {9'h1ff, rows[i][7:5], 4'hf});
      @(posedge clk) front_end_out <= post;
      waitc(3);
      wr(3'h3, 16'h0001);
      @(posedge clk) front_end_out <= pre;
      waitc(3);
      rd(3'h3, 16'h0000, "flag wrong edge");
      @(posedge clk) front_end_out <= post;
      waitc(3);
      check("flag out", {15'h0, scan_flag_zero_r}, 16'h0001);
      rd(3'h3, 16'h0001, "flag status");
      rd(3'h0, {9'h1ff, rows[i][7:5], post}, "reg0 fields");
    end
    rd(3'h5, 16'h0000, "unmapped");
    for (int i = 0; i < 4; i++)
    begin
      wr(3'h1, {1'b0, 1'b1, i[1:0], i[1:0], 10'h000});
      waitc(2);
      check("q7 used", {15'h0, state_bit_seven_used_r}, {15'h0, i[1]});
      check("q6 used", {15'h0, state_bit_six_used_r}, {15'h0, i[0]});
      check("cnt enables", {13'h0000, counter_enables_r}, {13'h0000, 1'b1, i[1:0]});
    end
    // enables on but state bits low: the gates must block, not just echo the enables
    @(posedge clk)
    begin
      state_bit_six <= 1'b0;
      state_bit_seven <= 1'b0;
    end
    waitc(2);
    check("q7 off", {15'h0, state_bit_seven_used_r}, 16'h0000);
    check("q6 off", {15'h0, state_bit_six_used_r}, 16'h0000);
    wr(3'h2, 16'h0000);
    repeat (3)
    begin
      @(posedge clk) count_event <= 1'b1;
      @(posedge clk) count_event <= 1'b0;
    end
    rd(3'h2, 16'h0003, "counter keep");
    rd(3'h2, 16'h0003, "counter kept");
    wr(3'h1, 16'h8000);
    rd(3'h2, 16'h0003, "counter clear read");
    rd(3'h2, 16'h0000, "counter cleared");
    for (int k = 0; k < 4; k++)
    begin
      sel = 0;
      wr(3'h1, {12'h000, k[1:0], 2'b00});
      measure(0, 16, 64);
      check("aux div", cnt, 16'(64 >> k));
      sel = 1;
      wr(3'h1, {14'h0000, k[1:0]});
      measure(1, 16, 64);
      check("sub div", cnt, 16'(64 >> k));
    end
    sel = 2;
    for (int t = 0; t < 3; t++)
    begin
      wr(3'h1, {7'h00, trig[t]});
      measure(0, 2 * trig_win[t], trig_win[t]);
      check("trigger", cnt, 16'(trig_exp[t]));
    end
    wr(3'h1, 16'h03f0);
    measure(0, 450, 900);
    check("trigger max", cnt, 16'h0002);
    results();
  end
endmodule
